// file: logic/isr_pkg.sv
// Constants and command codes for the instrument status reporting block.
// Assumes a single clock domain and a command parser that issues one decoded command at a time.
package isr_pkg;

	// Widths of the status structures.
	localparam int SB_W   = 8;
	localparam int ESR_W  = 8;
	localparam int OPER_W = 16;
	localparam int RSP_W  = 16;

	// Status byte bit positions.
	localparam int SB_OPER = 7;
	localparam int SB_RQS  = 6;
	localparam int SB_ESB  = 5;
	localparam int SB_MAV  = 4;
	localparam int SB_QUES = 3;
	localparam int SB_MSG  = 2;

	// Standard event status bit positions.
	localparam int ESR_PON = 7;
	localparam int ESR_URQ = 6;
	localparam int ESR_CME = 5;
	localparam int ESR_EXE = 4;
	localparam int ESR_DDE = 3;
	localparam int ESR_QYE = 2;
	localparam int ESR_RQC = 1;
	localparam int ESR_OPC = 0;

	// Operation condition and event bit positions.
	localparam int OPER_CAL  = 0;
	localparam int OPER_MEAS = 4;

	// Reset values and implemented-bit masks.
	localparam logic [SB_W-1:0]   SB_RST        = 8'h00;
	localparam logic [SB_W-1:0]   SRE_RST       = 8'h00;
	localparam logic [SB_W-1:0]   SRE_WR_MASK   = 8'hBF;
	localparam logic [ESR_W-1:0]  ESE_RST       = 8'h00;
	localparam logic [ESR_W-1:0]  ESR_RST       = 8'h00;
	localparam logic [ESR_W-1:0]  ESR_USED      = 8'hBD;
	localparam logic [OPER_W-1:0] OPER_ENA_RST  = 16'h0000;
	localparam logic [OPER_W-1:0] OPER_EVT_RST  = 16'h0000;
	localparam logic [OPER_W-1:0] OPER_USED     = 16'h0011;
	localparam logic [RSP_W-1:0]  RSP_RST       = 16'h0000;

	// Decoded commands handed over by the parser.
	typedef enum logic [3:0] {
		ISR_CMD_NONE      = 4'h0,
		ISR_CMD_CLS       = 4'h1,
		ISR_CMD_ESE_SET   = 4'h2,
		ISR_CMD_ESE_QRY   = 4'h3,
		ISR_CMD_ESR_QRY   = 4'h4,
		ISR_CMD_SRE_SET   = 4'h5,
		ISR_CMD_SRE_QRY   = 4'h6,
		ISR_CMD_STB_QRY   = 4'h7,
		ISR_CMD_OCOND_QRY = 4'h8,
		ISR_CMD_OEVT_QRY  = 4'h9,
		ISR_CMD_OENA_SET  = 4'hA,
		ISR_CMD_OENA_QRY  = 4'hB
	} isr_cmd_t;

endpackage

// file: logic/isr_evt_if.sv
// Link between the status core and one event register group.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface isr_evt_if #(
	parameter int W = 8
);
	logic [W-1:0] set;
	logic         clr;
	logic         mask_wr;
	logic [W-1:0] mask_wr_data;
	logic [W-1:0] evt;
	logic [W-1:0] mask;
	logic         summary;

	modport ctl (
		output set,
		output clr,
		output mask_wr,
		output mask_wr_data,
		input  evt,
		input  mask,
		input  summary
	);

	modport grp (
		input  set,
		input  clr,
		input  mask_wr,
		input  mask_wr_data,
		output evt,
		output mask,
		output summary
	);
endinterface

// file: logic/isr_evt_group.sv
// One sticky event register with its enable mask and masked summary.
// Assumes set and clear requests come from logic on the same clock.
`timescale 1ns/10ps
module isr_evt_group #(
	parameter int           W        = 8,
	parameter logic [W-1:0] USED     = '1,
	parameter logic [W-1:0] EVT_RST  = '0,
	parameter logic [W-1:0] MASK_RST = '0
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	isr_evt_if.grp    bus
);

	typedef struct packed {
		logic [W-1:0] evt;
		logic [W-1:0] mask;
		logic         summary;
	} isr_grp_state_t;

	isr_grp_state_t state;
	isr_grp_state_t next_state;

	always_comb begin
		next_state = state;
		// A set arriving with the clear survives it.
		next_state.evt = ((bus.clr ? '0 : state.evt) | bus.set) & USED;
		if (bus.mask_wr) begin
			next_state.mask = bus.mask_wr_data;
		end
		next_state.summary = |(next_state.evt & next_state.mask);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= '{evt: EVT_RST, mask: MASK_RST, summary: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign bus.evt     = state.evt;
	assign bus.mask    = state.mask;
	assign bus.summary = state.summary;

endmodule

// file: logic/isr_status_core.sv
// Status byte, service request and standard event status for a remote instrument.
// Assumes a command parser on mclk hands over one decoded command per cycle and
// that all event and condition inputs come from logic on the same clock.
`timescale 1ns/10ps

// What this block does
// - Status byte bit 7 is high while any operation is running.
// - Status query and serial poll return the same byte, differing only in bit 6.
// - Bit 6 is set when service request mask ANDed with status byte is nonzero.
// - Status byte bit 4 follows message available from the output queue.
// - Status byte bits 3, 1 and 0 always read zero.
// - Status byte bit 2 is high while new error or status messages wait.
// - Bit 5 is set when event mask ANDed with event status is nonzero.
// - Event bit 7 is set after power up and held until the register is read or status is cleared.
// - Event bit 5 is set on syntax error or trigger inside a message.
// - Event bit 4 is set on an out of range or impossible parameter.
// - Event bit 3 is set while the encoded message register is nonzero.
// - Event bit 2 is set on reading an empty output buffer or lost data.
// - Event bit 0 is set when pending operations finish after operation complete.
// - The service request mask is written by command and read back by query.
// - The event status mask is written by command and read back by query.
// - A 16-bit operation condition: bit 0 calibrating, bit 4 measuring.
// - A 16-bit operation event register latches events at the condition bit positions.
// - Operation event bit 0 on calibration done, bit 4 on single shot done.
// - Unused operation condition and event bits read as zero.
// - Clear status empties the event status register and operation events.
// - Writing the service request mask ignores bit 6.
module isr_status_core (
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic                        cmd_valid,
	input  wire isr_pkg::isr_cmd_t           cmd_code,
	input  wire logic [isr_pkg::RSP_W-1:0]   cmd_data,
	output logic                             rsp_valid,
	output logic [isr_pkg::RSP_W-1:0]        rsp_data,
	input  wire logic                        spoll_req,
	output logic                             spoll_valid,
	output logic [isr_pkg::SB_W-1:0]         spoll_byte,
	output logic                             srq,
	output logic [isr_pkg::SB_W-1:0]         status_byte,
	input  wire logic                        msg_avail,
	input  wire logic                        err_queue_nonempty,
	input  wire logic                        cmd_err,
	input  wire logic                        exec_err,
	input  wire logic                        enc_msg_nonzero,
	input  wire logic                        query_err,
	input  wire logic                        opc_done,
	input  wire logic                        cal_active,
	input  wire logic                        meas_active,
	input  wire logic                        single_shot_done
);

	typedef struct packed {
		logic                        rsp_valid;
		logic [isr_pkg::RSP_W-1:0]   rsp_data;
		logic                        spoll_valid;
		logic [isr_pkg::SB_W-1:0]    spoll_byte;
		logic [isr_pkg::SB_W-1:0]    status_byte;
		logic [isr_pkg::SB_W-1:0]    sre;
		logic                        rqs;
		logic                        mss_d;
		logic                        pon_pend;
		logic                        cal_d;
		logic [isr_pkg::OPER_W-1:0]  cond;
	} isr_core_state_t;

	isr_core_state_t state;
	isr_core_state_t next_state;

	isr_evt_if #(.W(isr_pkg::ESR_W))  esr_if ();
	isr_evt_if #(.W(isr_pkg::OPER_W)) oper_if ();

	isr_evt_group #(
		.W        (isr_pkg::ESR_W),
		.USED     (isr_pkg::ESR_USED),
		.EVT_RST  (isr_pkg::ESR_RST),
		.MASK_RST (isr_pkg::ESE_RST)
	) u_esr (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.bus     (esr_if)
	);

	isr_evt_group #(
		.W        (isr_pkg::OPER_W),
		.USED     (isr_pkg::OPER_USED),
		.EVT_RST  (isr_pkg::OPER_EVT_RST),
		.MASK_RST (isr_pkg::OPER_ENA_RST)
	) u_oper (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.bus     (oper_if)
	);

	logic                       take;
	logic                       cal_done;
	logic [isr_pkg::SB_W-1:0]   sb_base;
	logic                       mss;

	assign take = cmd_valid;

	// Calibration completion is the falling edge of the calibrating condition.
	assign cal_done = state.cal_d & ~state.cond[isr_pkg::OPER_CAL];

	// Standard event inputs and the mask written by command.
	always_comb begin
		esr_if.set                   = '0;
		esr_if.set[isr_pkg::ESR_PON] = state.pon_pend;
		esr_if.set[isr_pkg::ESR_CME] = cmd_err;
		esr_if.set[isr_pkg::ESR_EXE] = exec_err;
		esr_if.set[isr_pkg::ESR_DDE] = enc_msg_nonzero;
		esr_if.set[isr_pkg::ESR_QYE] = query_err;
		esr_if.set[isr_pkg::ESR_OPC] = opc_done;
		esr_if.clr = take && (cmd_code == isr_pkg::ISR_CMD_ESR_QRY ||
			cmd_code == isr_pkg::ISR_CMD_CLS);
		esr_if.mask_wr      = take && cmd_code == isr_pkg::ISR_CMD_ESE_SET;
		esr_if.mask_wr_data = cmd_data[isr_pkg::ESR_W-1:0];
	end

	// Operation event inputs, one bit per condition bit.
	always_comb begin
		oper_if.set                     = '0;
		oper_if.set[isr_pkg::OPER_CAL]  = cal_done;
		oper_if.set[isr_pkg::OPER_MEAS] = single_shot_done;
		oper_if.clr = take && (cmd_code == isr_pkg::ISR_CMD_OEVT_QRY ||
			cmd_code == isr_pkg::ISR_CMD_CLS);
		oper_if.mask_wr      = take && cmd_code == isr_pkg::ISR_CMD_OENA_SET;
		oper_if.mask_wr_data = cmd_data;
	end

	// Status byte without bit 6; the undefined bits stay zero.
	always_comb begin
		sb_base                  = isr_pkg::SB_RST;
		sb_base[isr_pkg::SB_OPER] = (|state.cond) | oper_if.summary;
		sb_base[isr_pkg::SB_ESB]  = esr_if.summary;
		sb_base[isr_pkg::SB_MAV]  = msg_avail;
		sb_base[isr_pkg::SB_MSG]  = err_queue_nonempty;
	end

	// Master summary from the enabled bits of the status byte.
	assign mss = |(sb_base & state.sre);

	always_comb begin
		next_state = state;
		next_state.rsp_valid   = 1'b0;
		next_state.spoll_valid = 1'b0;
		next_state.pon_pend    = 1'b0;

		// Condition register follows the running operations, unaffected by reads.
		next_state.cond                    = '0;
		next_state.cond[isr_pkg::OPER_CAL]  = cal_active;
		next_state.cond[isr_pkg::OPER_MEAS] = meas_active;
		next_state.cal_d                   = state.cond[isr_pkg::OPER_CAL];

		next_state.status_byte = sb_base;
		next_state.status_byte[isr_pkg::SB_RQS] = mss;
		next_state.mss_d = mss;

		// A serial poll clears the request, but a new request in that cycle wins.
		if (spoll_req) begin
			next_state.spoll_valid = 1'b1;
			next_state.spoll_byte  = state.status_byte;
			next_state.spoll_byte[isr_pkg::SB_RQS] = state.rqs;
			next_state.rqs = 1'b0;
		end

		if (take) begin
			case (cmd_code)
				isr_pkg::ISR_CMD_SRE_SET: begin
					next_state.sre = cmd_data[isr_pkg::SB_W-1:0] & isr_pkg::SRE_WR_MASK;
				end
				isr_pkg::ISR_CMD_SRE_QRY: begin
					next_state.rsp_valid = 1'b1;
					next_state.rsp_data  = {8'h00, state.sre};
				end
				isr_pkg::ISR_CMD_ESE_QRY: begin
					next_state.rsp_valid = 1'b1;
					next_state.rsp_data  = {8'h00, esr_if.mask};
				end
				isr_pkg::ISR_CMD_ESR_QRY: begin
					next_state.rsp_valid = 1'b1;
					next_state.rsp_data  = {8'h00, esr_if.evt};
				end
				isr_pkg::ISR_CMD_STB_QRY: begin
					next_state.rsp_valid = 1'b1;
					next_state.rsp_data  = {8'h00, state.status_byte};
				end
				isr_pkg::ISR_CMD_OCOND_QRY: begin
					next_state.rsp_valid = 1'b1;
					next_state.rsp_data  = state.cond;
				end
				isr_pkg::ISR_CMD_OEVT_QRY: begin
					next_state.rsp_valid = 1'b1;
					next_state.rsp_data  = oper_if.evt;
				end
				isr_pkg::ISR_CMD_OENA_QRY: begin
					next_state.rsp_valid = 1'b1;
					next_state.rsp_data  = oper_if.mask;
				end
				isr_pkg::ISR_CMD_CLS: begin
					// Event registers are cleared in their groups; a pending request is dropped.
					next_state.rqs = 1'b0;
				end
				default: begin
					next_state.rsp_valid = 1'b0;
				end
			endcase
		end

		// A rising master summary comes last so it outlives a poll or clear status.
		if (mss && !state.mss_d) begin
			next_state.rqs = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= '{
				rsp_valid:   1'b0,
				rsp_data:    isr_pkg::RSP_RST,
				spoll_valid: 1'b0,
				spoll_byte:  isr_pkg::SB_RST,
				status_byte: isr_pkg::SB_RST,
				sre:         isr_pkg::SRE_RST,
				rqs:         1'b0,
				mss_d:       1'b0,
				pon_pend:    1'b1,
				cal_d:       1'b0,
				cond:        isr_pkg::OPER_EVT_RST
			};
		end else begin
			state <= next_state;
		end
	end

	assign rsp_valid   = state.rsp_valid;
	assign rsp_data    = state.rsp_data;
	assign spoll_valid = state.spoll_valid;
	assign spoll_byte  = state.spoll_byte;
	assign srq         = state.rqs;
	assign status_byte = state.status_byte;

endmodule

// file: sim/isr_status_chk.sv
// Concurrent checks on the status core ports.
// Assumes the core runs on mclk with a synchronous active high reset.
`timescale 1ns/10ps
module isr_status_chk (
	input	wire logic			mclk,
	input	wire logic			sys_rst,
	input	wire logic			cmd_valid,
	input	wire isr_pkg::isr_cmd_t		cmd_code,
	input	wire logic			rsp_valid,
	input	wire logic [15:0]		rsp_data,
	input	wire logic			spoll_req,
	input	wire logic			spoll_valid,
	input	wire logic [7:0]		spoll_byte,
	input	wire logic			srq,
	input	wire logic [7:0]		status_byte,
	input	wire logic			msg_avail,
	input	wire logic			err_queue_nonempty,
	input	wire logic			meas_active
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	chk_resv_zero: assert property (status_byte[3] == 1'b0 && status_byte[1:0] == 2'h0)
		else $error("unused status bits set");
	chk_mav_follow: assert property (msg_avail |=> status_byte[4])
		else $error("message available missing");
	chk_msg_summary: assert property (##1 status_byte[2] == $past(err_queue_nonempty))
		else $error("message summary wrong");
	chk_poll_same: assert property (spoll_req |=> spoll_valid
		&& spoll_byte[7] == $past(status_byte[7]) && spoll_byte[5:0] == $past(status_byte[5:0]))
		else $error("poll byte differs");
	chk_srq_rise: assert property ($rose(status_byte[6]) |=> srq)
		else $error("service request not raised");
	chk_oper_bit: assert property (meas_active |-> ##2 status_byte[7])
		else $error("operation summary low");
	chk_sre_mask: assert property (cmd_valid && cmd_code == isr_pkg::ISR_CMD_SRE_QRY
		|=> rsp_valid && rsp_data[15:8] == 8'h00 && !rsp_data[6])
		else $error("service mask bit 6 kept");
	chk_oper_unused: assert property (cmd_valid && (cmd_code == isr_pkg::ISR_CMD_OCOND_QRY
		|| cmd_code == isr_pkg::ISR_CMD_OEVT_QRY) |=> rsp_valid && (rsp_data & 16'hFFEE) == 16'h0000)
		else $error("unused operation bits set");
endmodule
bind isr_status_core isr_status_chk isr_status_chk_inst (.mclk(mclk), .sys_rst(sys_rst),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
	.spoll_req(spoll_req), .spoll_valid(spoll_valid), .spoll_byte(spoll_byte), .srq(srq),
	.status_byte(status_byte), .msg_avail(msg_avail),
	.err_queue_nonempty(err_queue_nonempty), .meas_active(meas_active));

// file: sim/isr_host_model.sv
// Remote controller model that issues decoded commands and serial polls.
// Assumes requests from the bench arrive on mclk edges.
`timescale 1ns/10ps
module isr_host_model (
	input	wire logic			mclk,
	input	wire logic			go,
	input	wire isr_pkg::isr_cmd_t		go_code,
	input	wire logic [15:0]		go_data,
	input	wire logic			poll,
	output	logic				cmd_valid,
	output	isr_pkg::isr_cmd_t		cmd_code,
	output	logic [15:0]			cmd_data,
	output	logic				spoll_req
);
	// Idle data toggles every cycle so a stale word never looks like a write.
	initial begin
		cmd_valid = 1'b0;
		cmd_code = isr_pkg::ISR_CMD_NONE;
		cmd_data = 16'h5A5A;
		spoll_req = 1'b0;
	end
	always @(posedge mclk) begin
		cmd_valid <= go;
		cmd_code <= go ? go_code : isr_pkg::ISR_CMD_NONE;
		cmd_data <= go ? go_data : ~cmd_data;
		spoll_req <= poll;
	end
endmodule

// file: sim/instrument_status_reporting_bench.sv
// Self-checking bench for the status core with an integer reference model.
// Assumes the package, core, host model and checker are compiled first.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin compares++; if (32'(gt) !== 32'(ex)) begin failures++; \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module instrument_status_reporting_bench;
	logic			mclk = 0, sys_rst = 1, go = 0, poll = 0, msg = 0, errq = 0, cal = 0, meas = 0;
	logic [5:0]		ev = 6'h00;
	logic [15:0]		go_data = 16'h0000, cmd_data, rsp_data;
	logic			cmd_valid, spoll_req, rsp_valid, spoll_valid, srq;
	logic [7:0]		spoll_byte, status_byte;
	isr_pkg::isr_cmd_t	go_code = isr_pkg::ISR_CMD_NONE, cmd_code;
	int			failures = 0, compares = 0, seed = 81, r, standard_event_status;
	int			eb[5] = '{0, 2, 3, 4, 5};
	always #5 mclk = ~mclk;
	isr_host_model isr_host_model_inst (.mclk(mclk), .go(go), .go_code(go_code), .go_data(go_data),
		.poll(poll), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.spoll_req(spoll_req));
	isr_status_core isr_status_core_inst (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.spoll_req(spoll_req), .spoll_valid(spoll_valid), .spoll_byte(spoll_byte), .srq(srq),
		.status_byte(status_byte), .msg_avail(msg), .err_queue_nonempty(errq), .cmd_err(ev[4]),
		.exec_err(ev[3]), .enc_msg_nonzero(ev[2]), .query_err(ev[1]), .opc_done(ev[0]),
		.cal_active(cal), .meas_active(meas), .single_shot_done(ev[5]));
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic send(input isr_pkg::isr_cmd_t c, input int d);
		@(posedge mclk);
		go <= 1'b1;
		go_code <= c;
		go_data <= 16'(d);
		@(posedge mclk);
		go <= 1'b0;
		#1;
	endtask
	task automatic query(input isr_pkg::isr_cmd_t c, input int ex, input string nm);
		int n;
		send(c, 0);
		n = 0;
		while (rsp_valid !== 1'b1 && n < 6) begin
			tick(1);
			n++;
		end
		`CHK("rvalid", 1, rsp_valid)
		`CHK(nm, ex, rsp_data)
	endtask
	task automatic pulse(input int i);
		@(posedge mclk);
		ev[i] <= 1'b1;
		@(posedge mclk);
		ev[i] <= 1'b0;
		tick(3);
	endtask
	task automatic complete_run();
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		tick(2);
		query(isr_pkg::ISR_CMD_ESR_QRY, 'h80, "esr");
		query(isr_pkg::ISR_CMD_ESR_QRY, 0, "esr");
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			send(isr_pkg::ISR_CMD_SRE_SET, r & 'hFF);
			query(isr_pkg::ISR_CMD_SRE_QRY, r & 'hBF, "sre");
			send(isr_pkg::ISR_CMD_ESE_SET, (r >> 8) & 'hFF);
			query(isr_pkg::ISR_CMD_ESE_QRY, (r >> 8) & 'hFF, "ese");
		end
		send(isr_pkg::ISR_CMD_ESE_SET, 'hFF);
		send(isr_pkg::ISR_CMD_SRE_SET, 0);
		for (int i = 0; i < 5; i++) begin
			standard_event_status = 1 << eb[i];
			pulse(i);
			`CHK("esb", 1, status_byte[5])
			query(isr_pkg::ISR_CMD_ESR_QRY, standard_event_status, "esr");
			tick(3);
			`CHK("esb", 0, status_byte[5])
		end
		send(isr_pkg::ISR_CMD_SRE_SET, 'h20);
		pulse(4);
		tick(1);
		`CHK("mss", 1, status_byte[6])
		`CHK("srq", 1, srq)
		@(posedge mclk);
		poll <= 1'b1;
		@(posedge mclk);
		poll <= 1'b0;
		tick(1);
		`CHK("pvalid", 1, spoll_valid)
		`CHK("poll", 'h60, spoll_byte)
		tick(1);
		`CHK("srq", 0, srq)
		query(isr_pkg::ISR_CMD_STB_QRY, 'h60, "stb");
		send(isr_pkg::ISR_CMD_CLS, 0);
		tick(3);
		`CHK("sb", 0, status_byte)
		query(isr_pkg::ISR_CMD_ESR_QRY, 0, "esr");
		@(posedge mclk);
		meas <= 1'b1;
		tick(3);
		`CHK("oper", 1, status_byte[7])
		query(isr_pkg::ISR_CMD_OCOND_QRY, 'h10, "ocond");
		query(isr_pkg::ISR_CMD_OCOND_QRY, 'h10, "ocond");
		@(posedge mclk);
		meas <= 1'b0;
		cal <= 1'b1;
		tick(3);
		query(isr_pkg::ISR_CMD_OCOND_QRY, 'h01, "ocond");
		@(posedge mclk);
		cal <= 1'b0;
		pulse(5);
		query(isr_pkg::ISR_CMD_OEVT_QRY, 'h11, "oevt");
		query(isr_pkg::ISR_CMD_OEVT_QRY, 0, "oevt");
		`CHK("oper", 0, status_byte[7])
		send(isr_pkg::ISR_CMD_OENA_SET, 'h10);
		query(isr_pkg::ISR_CMD_OENA_QRY, 'h10, "oena");
		pulse(5);
		`CHK("oper", 1, status_byte[7])
		send(isr_pkg::ISR_CMD_CLS, 0);
		tick(3);
		`CHK("oper", 0, status_byte[7])
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			@(posedge mclk);
			msg <= r[0];
			errq <= r[1];
			tick(2);
			`CHK("mav", r[0], status_byte[4])
			`CHK("msgq", r[1], status_byte[2])
			`CHK("zero", 0, status_byte & 8'h0B)
		end
		@(posedge mclk);
		sys_rst <= 1'b1;
		tick(2);
		`CHK("rst", 0, {srq, spoll_valid, rsp_valid, status_byte})
		@(posedge mclk);
		sys_rst <= 1'b0;
		tick(2);
		query(isr_pkg::ISR_CMD_ESR_QRY, 'h80, "esr");
		query(isr_pkg::ISR_CMD_SRE_QRY, 0, "sre");
		complete_run();
	end
endmodule
